// File: hw/pcm_monitor.v
`timescale 1ns/1ps
`include "pcm_regs.vh"

module pcm_monitor (
    // Clock and reset.
    input  wire        mclk,
    input  wire        nrst,
    // Register port.
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Position and alarm sources on the system clock.
    input  wire [31:0] fb_pos,
    input  wire [31:0] fb_pos_wrapped,
    input  wire [31:0] cmd_pos,
    input  wire [31:0] cmd_pos_wrapped,
    input  wire [7:0]  alarm_code,
    input  wire        shaft_phase_a,
    input  wire        shaft_phase_b,
    // Pins from the master controller.
    input  wire        readout_request_0,
    input  wire        readout_request_1,
    input  wire        readout_shift_clock,
    input  wire        pulse_replay_request,
    // Pins to the master controller.
    output reg         readout_serial_out,
    output reg         quad_phase_a_out,
    output reg         quad_phase_b_out,
    output reg         pulse_replay_ready
);

    // ****************************************************************
    // Functions.
    // ****************************************************************

    // Picks a position: kind bit 1 selects command side, bit 0 the counter.
    function [31:0] pick_pos;
        input [1:0]  kind;
        input        wrap;
        input [31:0] fb_raw;
        input [31:0] fb_wr;
        input [31:0] cmd_raw;
        input [31:0] cmd_wr;
        begin
            case (kind)
                2'h0:    pick_pos = wrap ? fb_wr : fb_raw;
                2'h1:    pick_pos = fb_raw;
                2'h2:    pick_pos = wrap ? cmd_wr : cmd_raw;
                default: pick_pos = cmd_raw;
            endcase
        end
    endfunction

    // Accepts only the documented selection codes.
    function sel_ok;
        input [3:0] code;
        begin
            sel_ok = (code >= `PCM_SEL_POS_LO && code <= `PCM_SEL_POS_HI) ||
                     (code == `PCM_SEL_ALARM) ||
                     (code >= `PCM_SEL_BOTH_LO && code <= `PCM_SEL_BOTH_HI);
        end
    endfunction

    // Sum of bytes, kept to the low eight bits.
    function [7:0] byte_sum;
        input [31:0] pos;
        input [7:0]  alarm;
        input        has_pos;
        input        has_alarm;
        begin
            byte_sum = 8'h00;
            if (has_pos) begin
                byte_sum = pos[7:0] + pos[15:8] + pos[23:16] + pos[31:24];
            end
            if (has_alarm) begin
                byte_sum = byte_sum + alarm;
            end
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers and edge detectors.
    // ****************************************************************

    reg  [3:0]  sync1_r;
    reg  [3:0]  sync2_r;
    reg  [3:0]  prev_r;
    wire        req0_lvl  = sync2_r[0];
    wire        req1_lvl  = sync2_r[1];
    wire        sclk_rise = sync2_r[2] & ~prev_r[2];
    wire        rpreq_lvl = sync2_r[3];
    wire        req0_rise = sync2_r[0] & ~prev_r[0];
    wire        req1_rise = sync2_r[1] & ~prev_r[1];
    wire        rp_rise   = sync2_r[3] & ~prev_r[3];

    // Two flops per pin; the third stage only feeds edge detection.
    always @(posedge mclk) begin
        if (!nrst) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            prev_r  <= 4'h0;
        end else begin
            sync1_r <= {pulse_replay_request, readout_shift_clock,
                        readout_request_1, readout_request_0};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // ****************************************************************
    // Configuration registers.
    // ****************************************************************

    reg  [3:0]  sel0_r;
    reg  [3:0]  sel1_r;
    reg  [1:0]  rp_src_r;
    reg  [13:0] rp_rate_r;
    reg         wrap_r;

    // Invalid codes and out-of-range rates are ignored so the block never runs undefined.
    always @(posedge mclk) begin
        if (!nrst) begin
            sel0_r    <= `PCM_SEL0_RST;
            sel1_r    <= `PCM_SEL1_RST;
            rp_src_r  <= `PCM_RP_SRC_RST;
            rp_rate_r <= `PCM_RP_RATE_RST;
            wrap_r    <= `PCM_WRAP_RST;
        end else if (reg_wr) begin
            if (reg_addr == `PCM_OFF_SEL0) begin
                if (sel_ok(reg_wdata[3:0]) && reg_wdata[31:4] == 28'h0000000) begin
                    sel0_r <= reg_wdata[3:0];
                end
            end else if (reg_addr == `PCM_OFF_SEL1) begin
                if (sel_ok(reg_wdata[3:0]) && reg_wdata[31:4] == 28'h0000000) begin
                    sel1_r <= reg_wdata[3:0];
                end
            end else if (reg_addr == `PCM_OFF_RP_SRC) begin
                rp_src_r <= reg_wdata[1:0];
            end else if (reg_addr == `PCM_OFF_RP_RATE) begin
                if (reg_wdata[31:14] == 18'h00000 &&
                    reg_wdata[13:0] >= `PCM_RP_RATE_MIN &&
                    reg_wdata[13:0] <= `PCM_RP_RATE_MAX) begin
                    rp_rate_r <= reg_wdata[13:0];
                end
            end else if (reg_addr == `PCM_OFF_WRAP) begin
                wrap_r <= reg_wdata[0];
            end
        end
    end

    // ****************************************************************
    // Serial readout.
    // ****************************************************************

    reg  [47:0] rd_sr_r;
    reg  [5:0]  rd_left_r;
    reg         rd_active_r;
    reg         rd_owner_r;
    wire [3:0]  rd_sel     = req0_rise ? sel0_r : sel1_r;
    wire        rd_has_pos = (rd_sel >= `PCM_SEL_POS_LO && rd_sel <= `PCM_SEL_POS_HI) ||
                             (rd_sel >= `PCM_SEL_BOTH_LO && rd_sel <= `PCM_SEL_BOTH_HI);
    wire        rd_has_alm = (rd_sel == `PCM_SEL_ALARM) ||
                             (rd_sel >= `PCM_SEL_BOTH_LO && rd_sel <= `PCM_SEL_BOTH_HI);
    wire [1:0]  rd_kind    = rd_sel[1:0] - 2'h1;
    wire [31:0] rd_pos     = pick_pos(rd_kind, wrap_r, fb_pos, fb_pos_wrapped,
                                      cmd_pos, cmd_pos_wrapped);
    wire [7:0]  rd_sum     = byte_sum(rd_pos, alarm_code, rd_has_pos, rd_has_alm);
    wire        owner_lvl  = rd_owner_r ? req1_lvl : req0_lvl;
    reg  [47:0] rd_frame;
    reg  [5:0]  rd_len;

    // Frame assembly: bit 0 leaves first, so low fields sit in low bits.
    always @* begin
        rd_frame = 48'h000000000000;
        rd_len   = 6'h00;
        if (rd_has_pos && rd_has_alm) begin
            rd_frame = {rd_sum, alarm_code, rd_pos};
            rd_len   = `PCM_LEN_BOTH;
        end else if (rd_has_pos) begin
            rd_frame = {8'h00, rd_sum, rd_pos};
            rd_len   = `PCM_LEN_POS;
        end else if (rd_has_alm) begin
            rd_frame = {32'h00000000, rd_sum, alarm_code};
            rd_len   = `PCM_LEN_ALARM;
        end
    end

    // Request 0 wins if both rise together; a drop of the owning request aborts.
    always @(posedge mclk) begin
        if (!nrst) begin
            rd_sr_r            <= 48'h000000000000;
            rd_left_r          <= 6'h00;
            rd_active_r        <= 1'b0;
            rd_owner_r         <= 1'b0;
            readout_serial_out <= 1'b0;
        end else if (!rd_active_r && (req0_rise || req1_rise)) begin
            rd_sr_r            <= rd_frame;
            rd_left_r          <= rd_len;
            rd_active_r        <= 1'b1;
            rd_owner_r         <= ~req0_rise;
            readout_serial_out <= 1'b1;
        end else if (rd_active_r && !owner_lvl) begin
            rd_active_r        <= 1'b0;
            rd_left_r          <= 6'h00;
            readout_serial_out <= 1'b0;
        end else if (rd_active_r && sclk_rise) begin
            if (rd_left_r != 6'h00) begin
                readout_serial_out <= rd_sr_r[0];
                rd_sr_r            <= {1'b0, rd_sr_r[47:1]};
                rd_left_r          <= rd_left_r - 6'h01;
            end else begin
                readout_serial_out <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Pulse replay.
    // ****************************************************************

    reg         rp_frozen_r;
    reg         rp_run_r;
    reg         rp_neg_r;
    reg  [31:0] rp_left_r;
    reg  [27:0] rp_acc_r;
    wire [31:0] rp_pos   = pick_pos({~rp_src_r[1], rp_src_r[0]}, wrap_r, fb_pos,
                                    fb_pos_wrapped, cmd_pos, cmd_pos_wrapped);
    wire [31:0] rp_mag   = rp_pos[31] ? (32'h00000000 - rp_pos) : rp_pos;
    wire [27:0] rp_inc   = {14'h0000, rp_rate_r} * {21'h000000, `PCM_RATE_UNIT_HZ};
    wire [27:0] rp_sum   = rp_acc_r + rp_inc;
    wire        rp_tick  = rp_sum >= `PCM_CLK_HZ;

    // Phase accumulator sets the edge rate without a divider by a variable.
    always @(posedge mclk) begin
        if (!nrst) begin
            rp_frozen_r        <= 1'b0;
            rp_run_r           <= 1'b0;
            rp_neg_r           <= 1'b0;
            rp_left_r          <= 32'h00000000;
            rp_acc_r           <= 28'h0000000;
            pulse_replay_ready <= 1'b0;
            quad_phase_a_out   <= 1'b0;
            quad_phase_b_out   <= 1'b0;
        end else if (!rp_frozen_r) begin
            quad_phase_a_out <= shaft_phase_a;
            quad_phase_b_out <= shaft_phase_b;
            if (rp_rise) begin
                rp_frozen_r        <= 1'b1;
                quad_phase_a_out   <= quad_phase_a_out;
                quad_phase_b_out   <= quad_phase_b_out;
                rp_neg_r           <= rp_pos[31];
                rp_left_r          <= rp_mag;
                rp_acc_r           <= 28'h0000000;
                pulse_replay_ready <= 1'b1;
            end
        end else if (!rpreq_lvl) begin
            rp_frozen_r        <= 1'b0;
            rp_run_r           <= 1'b0;
            pulse_replay_ready <= 1'b0;
        end else if (!rp_run_r) begin
            if (pulse_replay_ready && sclk_rise) begin
                rp_run_r <= 1'b1;
            end
        end else if (rp_left_r == 32'h00000000) begin
            pulse_replay_ready <= 1'b0;
        end else if (rp_tick) begin
            rp_acc_r  <= rp_sum - `PCM_CLK_HZ;
            rp_left_r <= rp_left_r - 32'h00000001;
            if (!rp_neg_r) begin
                quad_phase_a_out <= ~quad_phase_b_out;
                quad_phase_b_out <= quad_phase_a_out;
            end else begin
                quad_phase_a_out <= quad_phase_b_out;
                quad_phase_b_out <= ~quad_phase_a_out;
            end
        end else begin
            rp_acc_r <= rp_sum;
        end
    end

    // ****************************************************************
    // Register read port.
    // ****************************************************************

    // Read data stands one cycle after the strobe; unmapped reads give zero.
    always @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `PCM_OFF_SEL0) begin
                reg_rdata <= {28'h0000000, sel0_r};
            end else if (reg_addr == `PCM_OFF_SEL1) begin
                reg_rdata <= {28'h0000000, sel1_r};
            end else if (reg_addr == `PCM_OFF_RP_SRC) begin
                reg_rdata <= {30'h00000000, rp_src_r};
            end else if (reg_addr == `PCM_OFF_RP_RATE) begin
                reg_rdata <= {18'h00000, rp_rate_r};
            end else if (reg_addr == `PCM_OFF_WRAP) begin
                reg_rdata <= {31'h00000000, wrap_r};
            end else if (reg_addr == `PCM_OFF_STATUS) begin
                reg_rdata <= {27'h0000000, rp_frozen_r, rp_run_r,
                              pulse_replay_ready, rd_owner_r, rd_active_r};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

// File: hw/pcm_regs.vh
`ifndef PCM_REGS_VH
`define PCM_REGS_VH

// ****************************************************************
// Register map of the position coordinate monitor.
// ****************************************************************

`define PCM_OFF_SEL0        8'h00
`define PCM_OFF_SEL1        8'h04
`define PCM_OFF_RP_SRC      8'h08
`define PCM_OFF_RP_RATE     8'h0C
`define PCM_OFF_WRAP        8'h10
`define PCM_OFF_STATUS      8'h14

// ****************************************************************
// Field positions, reset values and replay rate limits.
// ****************************************************************

`define PCM_ST_RD_ACTIVE    0
`define PCM_ST_RD_OWNER     1
`define PCM_ST_RP_READY     2
`define PCM_ST_RP_RUN       3
`define PCM_ST_RP_FROZEN    4
`define PCM_SEL0_RST        4'h1
`define PCM_SEL1_RST        4'h8
`define PCM_RP_SRC_RST      2'h0
`define PCM_RP_RATE_RST     14'h0064
`define PCM_RP_RATE_MIN     14'h0001
`define PCM_RP_RATE_MAX     14'h2710
`define PCM_WRAP_RST        1'h0

// ****************************************************************
// Selection codes and frame lengths in bits.
// ****************************************************************

`define PCM_SEL_POS_LO      4'h1
`define PCM_SEL_POS_HI      4'h4
`define PCM_SEL_ALARM       4'h8
`define PCM_SEL_BOTH_LO     4'h9
`define PCM_SEL_BOTH_HI     4'hC
`define PCM_LEN_POS         6'h28
`define PCM_LEN_ALARM       6'h10
`define PCM_LEN_BOTH        6'h30

// ****************************************************************
// Timing: system clock in hertz and the replay rate unit in hertz.
// ****************************************************************

`define PCM_CLK_HZ          28'h5F5E100
`define PCM_RATE_UNIT_HZ    7'h64

`endif

// File: verif/pcm_monitor_properties.sv
`timescale 1ns/1ps

// ****
// Pin-level checks of the position coordinate monitor.
// ****
module pcm_monitor_properties (
    // Clock and reset.
    input logic mclk,
    input logic nrst,
    // Shaft phases and pins from the controller.
    input logic shaft_phase_a,
    input logic shaft_phase_b,
    input logic readout_request_0,
    input logic readout_request_1,
    input logic readout_shift_clock,
    input logic pulse_replay_request,
    // Pins to the controller.
    input logic readout_serial_out,
    input logic quad_phase_a_out,
    input logic quad_phase_b_out,
    input logic pulse_replay_ready
);
    logic [1:0] qv;
    logic [2:0] prv_r;
    logic [3:0] q_age_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Cycles since a request changed or the shift clock rose; only those may move the bit.
    assign qv = {quad_phase_a_out, quad_phase_b_out};
    always @(posedge mclk) begin
        prv_r <= {readout_request_0, readout_request_1, readout_shift_clock};
        if (!nrst || prv_r[2:1] != {readout_request_0, readout_request_1})
            q_age_r <= 4'h0;
        else if (!prv_r[0] && readout_shift_clock)
            q_age_r <= 4'h0;
        else if (q_age_r != 4'hF)
            q_age_r <= q_age_r + 4'h1;
    end

    property p_req0_ready;
        $rose(readout_request_0) && !readout_request_1 |-> ##[2:6] readout_serial_out;
    endproperty
    a_req0_ready: assert property (p_req0_ready)
        else $error("serial output not raised after request 0");

    property p_req1_ready;
        $rose(readout_request_1) && !readout_request_0 |=> ##[1:5] readout_serial_out;
    endproperty
    a_req1_ready: assert property (p_req1_ready)
        else $error("serial output not raised after request 1");

    property p_quiet;
        q_age_r > 4'h7 |-> $stable(readout_serial_out);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("serial output moved without a shift clock rise");

    property p_freeze;
        $rose(pulse_replay_ready) |=> $stable(qv)[*4];
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("phase outputs not frozen at replay ready");

    property p_rp_rise;
        $rose(pulse_replay_ready) |-> pulse_replay_request && $past(pulse_replay_request, 2);
    endproperty
    a_rp_rise: assert property (p_rp_rise)
        else $error("replay ready without a replay request");

    property p_follow;
        (nrst && !pulse_replay_request)[*8] |=> qv == $past({shaft_phase_a, shaft_phase_b});
    endproperty
    a_follow: assert property (p_follow)
        else $error("phase outputs do not follow the shaft");

    property p_gray;
        pulse_replay_ready && $changed(qv) |-> $onehot(qv ^ $past(qv));
    endproperty
    a_gray: assert property (p_gray)
        else $error("replay phase step is not a single quadrature edge");

    property p_done;
        $fell(pulse_replay_ready) && pulse_replay_request
            |-> $changed(qv) || $past(qv) != $past(qv, 2) || $past(qv, 2) != $past(qv, 3);
    endproperty
    a_done: assert property (p_done)
        else $error("replay ready dropped away from the last edge");
endmodule

// File: verif/pcm_host_model.sv
`timescale 1ns/1ps

// ****
// Master controller: serial reader and quadrature counter.
// ****
module pcm_host_model (
    // Clock.
    input  logic mclk,
    // From the monitor.
    input  logic readout_serial_out,
    input  logic quad_phase_a_out,
    input  logic quad_phase_b_out,
    input  logic pulse_replay_ready,
    // To the monitor.
    output logic readout_request_0,
    output logic readout_request_1,
    output logic readout_shift_clock,
    output logic pulse_replay_request
);
    logic [1:0]  prv_q_r;
    logic [31:0] enc_cnt_r;

    // The shift clock stands low outside frames and the replay start pulse.
    initial begin
        readout_request_0 = 1'b0;
        readout_request_1 = 1'b0;
        readout_shift_clock = 1'b0;
        pulse_replay_request = 1'b0;
        prv_q_r = 2'h0;
        enc_cnt_r = 32'h0;
    end

    // Counter counts up when A leads B and down when B leads A.
    always @(posedge mclk) begin
        prv_q_r <= {quad_phase_a_out, quad_phase_b_out};
        if ({quad_phase_a_out, quad_phase_b_out} === {~prv_q_r[0], prv_q_r[1]})
            enc_cnt_r <= enc_cnt_r + 32'h1;
        else if ({quad_phase_a_out, quad_phase_b_out} === {prv_q_r[0], ~prv_q_r[1]})
            enc_cnt_r <= enc_cnt_r - 32'h1;
    end

    // Read n bits; each is sampled late in the low half, long after it settled.
    task read_frame(input logic sel, input int n, output logic [47:0] bits);
        int   k;
        logic b;
        bits = 48'h0;
        k = 0;
        @(posedge mclk);
        readout_request_0 <= ~sel;
        readout_request_1 <= sel;
        while (readout_serial_out !== 1'b1 && k < 40) begin
            @(posedge mclk);
            k = k + 1;
        end
        // The shift clock runs far above the host limit to keep runs short.
        for (int i = 0; i < n; i++) begin
            #3 readout_shift_clock = 1'b1;
            #62.5 readout_shift_clock = 1'b0;
            #35 b = readout_serial_out;
            bits[i] = b;
            #24.5;
        end
        // A ready that never came spoils the frame, so the compare counts it.
        if (k == 40)
            bits = {48{1'b1}};
        @(posedge mclk);
        readout_request_0 <= 1'b0;
        readout_request_1 <= 1'b0;
        repeat (16) @(posedge mclk);
    endtask

    // Replay: counter cleared only once ready is seen, since phases still move before.
    task replay(output logic [31:0] cnt, output int dur);
        int k;
        k = 0;
        dur = 0;
        @(posedge mclk);
        pulse_replay_request <= 1'b1;
        while (pulse_replay_ready !== 1'b1 && k < 40) begin
            @(posedge mclk);
            k = k + 1;
        end
        #1 enc_cnt_r = 32'h0;
        #3 readout_shift_clock = 1'b1;
        #62.5 readout_shift_clock = 1'b0;
        while (pulse_replay_ready === 1'b1 && dur < 20000) begin
            @(posedge mclk);
            dur = dur + 1;
        end
        cnt = enc_cnt_r;
        @(posedge mclk);
        pulse_replay_request <= 1'b0;
        repeat (16) @(posedge mclk);
    endtask
endmodule

// File: verif/pcm_monitor_tb_top.sv
`timescale 1ns/1ps
`include "pcm_regs.vh"

// ****
// Self-checking bench for the position coordinate monitor.
// ****
module pcm_monitor_tb_top;
    logic        mclk, nrst, reg_wr, reg_rd, shaft_phase_a, shaft_phase_b, spin;
    logic        readout_request_0, readout_request_1, readout_shift_clock;
    logic        pulse_replay_request, readout_serial_out, pulse_replay_ready;
    logic        quad_phase_a_out, quad_phase_b_out;
    logic [7:0]  reg_addr, alarm_code;
    logic [31:0] reg_wdata, reg_rdata, fb_pos, fb_pos_wrapped, cmd_pos, cmd_pos_wrapped;
    logic [31:0] cnt, exp_v;
    logic [47:0] bits;
    logic [3:0]  c;
    int          dur, v, fails, n_compared;

    pcm_monitor dut (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fb_pos(fb_pos),
        .fb_pos_wrapped(fb_pos_wrapped), .cmd_pos(cmd_pos), .cmd_pos_wrapped(cmd_pos_wrapped),
        .alarm_code(alarm_code), .shaft_phase_a(shaft_phase_a), .shaft_phase_b(shaft_phase_b),
        .readout_request_0(readout_request_0), .readout_request_1(readout_request_1),
        .readout_shift_clock(readout_shift_clock), .pulse_replay_request(pulse_replay_request),
        .readout_serial_out(readout_serial_out), .quad_phase_a_out(quad_phase_a_out),
        .quad_phase_b_out(quad_phase_b_out), .pulse_replay_ready(pulse_replay_ready)
    );
    pcm_host_model host (
        .mclk(mclk), .readout_serial_out(readout_serial_out),
        .quad_phase_a_out(quad_phase_a_out), .quad_phase_b_out(quad_phase_b_out),
        .pulse_replay_ready(pulse_replay_ready), .readout_request_0(readout_request_0),
        .readout_request_1(readout_request_1), .readout_shift_clock(readout_shift_clock),
        .pulse_replay_request(pulse_replay_request)
    );

    always #5 mclk = ~mclk;

    // Shaft turns one quadrature step per cycle while spin is set.
    always @(posedge mclk)
        if (spin)
            {shaft_phase_a, shaft_phase_b} <= {~shaft_phase_b, shaft_phase_a};

    task check(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look just past that edge.
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask

    // Frame bits in send order: position, alarm, then the byte sum.
    function automatic logic [47:0] frame(input logic [3:0] code, input logic w);
        logic [31:0] p;
        logic [7:0]  s;
        case (code[1:0])
            2'h1: p = w ? fb_pos_wrapped : fb_pos;
            2'h2: p = fb_pos;
            2'h3: p = w ? cmd_pos_wrapped : cmd_pos;
            default: p = cmd_pos;
        endcase
        s = p[7:0] + p[15:8] + p[23:16] + p[31:24];
        if (code == 4'h8)
            return {32'h0, alarm_code, alarm_code};
        if (code < 4'h8)
            return {8'h0, s, p};
        return {s + alarm_code, alarm_code, p};
    endfunction

    task give_verdict;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // The tests need well under ten thousand cycles; twenty thousand means a hang.
    initial begin
        #200000;
        fails++;
        give_verdict;
    end

    // Positions stay still during every readout.
    initial begin
        {mclk, nrst, reg_wr, reg_rd, shaft_phase_a, shaft_phase_b, spin} = 7'h00;
        {reg_addr, reg_wdata} = 40'h0;
        {fb_pos, fb_pos_wrapped} = {32'h000002BC, 32'hFFFFFED4};
        {cmd_pos, cmd_pos_wrapped, alarm_code} = {32'h12345678, 32'h80000001, 8'h66};
        {fails, n_compared} = 0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(`PCM_OFF_SEL0, 32'h1);
        rd_chk(`PCM_OFF_SEL1, 32'h8);
        rd_chk(`PCM_OFF_RP_SRC, 32'h0);
        rd_chk(`PCM_OFF_RP_RATE, 32'h64);
        rd_chk(`PCM_OFF_WRAP, 32'h0);
        rd_chk(8'h20, 32'h0);
        rd_chk(`PCM_OFF_STATUS, 32'h0);
        wr(`PCM_OFF_SEL0, 32'h5);
        wr(`PCM_OFF_RP_RATE, 32'h0);
        rd_chk(`PCM_OFF_SEL0, 32'h1);
        rd_chk(`PCM_OFF_RP_RATE, 32'h64);
        host.read_frame(1'b0, 40, bits);
        check(bits, frame(4'h1, 1'b0));
        host.read_frame(1'b1, 16, bits);
        check(bits, frame(4'h8, 1'b0));
        wr(`PCM_OFF_WRAP, 32'h1);
        for (int i = 0; i < 8; i++) begin
            c = i[3:0] + ((i < 4) ? 4'h1 : 4'h5);
            wr(`PCM_OFF_SEL1, {28'h0, c});
            host.read_frame(1'b1, (c < 4'h9) ? 40 : 48, bits);
            check(bits, frame(c, 1'b1));
        end
        @(posedge mclk);
        {fb_pos, fb_pos_wrapped} <= {32'h4, 32'hFFFFFFFE};
        {cmd_pos, cmd_pos_wrapped} <= {32'h6, 32'hFFFFFFFD};
        spin <= 1'b1;
        wr(`PCM_OFF_RP_RATE, 32'h2710);
        rd_chk(`PCM_OFF_RP_RATE, 32'h2710);
        for (int i = 0; i < 4; i++) begin
            wr(`PCM_OFF_RP_SRC, {30'h0, i[1:0]});
            exp_v = (i == 0) ? cmd_pos_wrapped : (i == 1) ? cmd_pos :
                    (i == 2) ? fb_pos_wrapped : fb_pos;
            v = int'(exp_v);
            v = (v < 0) ? -v : v;
            host.replay(cnt, dur);
            check(cnt, exp_v);
            check(dur > v * 100 - 15 && dur < v * 100 + 15, 48'h1);
        end
        spin <= 1'b0;
        give_verdict;
    end
endmodule

bind pcm_monitor pcm_monitor_properties u_props (
    .mclk(mclk), .nrst(nrst), .shaft_phase_a(shaft_phase_a), .shaft_phase_b(shaft_phase_b),
    .readout_request_0(readout_request_0), .readout_request_1(readout_request_1),
    .readout_shift_clock(readout_shift_clock), .pulse_replay_request(pulse_replay_request),
    .readout_serial_out(readout_serial_out), .quad_phase_a_out(quad_phase_a_out),
    .quad_phase_b_out(quad_phase_b_out), .pulse_replay_ready(pulse_replay_ready)
);
